// ==== ioeseq_consts.svh ====
`ifndef IOESEQ_CONSTS_SVH
`define IOESEQ_CONSTS_SVH
// expander command register numbers
`define IOESEQ_REG_IN_LO 3'h0
`define IOESEQ_REG_IN_HI 3'h1
`define IOESEQ_REG_OUT_LO 3'h2
`define IOESEQ_REG_OUT_HI 3'h3
`define IOESEQ_REG_POL_LO 3'h4
`define IOESEQ_REG_POL_HI 3'h5
`define IOESEQ_REG_DIR_LO 3'h6
`define IOESEQ_REG_DIR_HI 3'h7
// fixed data values
`define IOESEQ_NO_INVERT 8'h00
`define IOESEQ_ALL_INPUTS 8'hff
`define IOESEQ_ALL_OUTPUTS 8'h00
// expander numbers
`define IOESEQ_EXP_HP0 3'h0
`define IOESEQ_EXP_HP1 3'h1
`define IOESEQ_EXP_PG 3'h2
`define IOESEQ_EXP_LED 3'h4
// steps per sequence, widest variant
`define IOESEQ_STEPS 4'h8
`endif

// ==== ioeseq_pkg.sv ====
package ioeseq_pkg;
  // sequencer states
  typedef enum logic [1:0]
  {
    IOESEQ_IDLE = 2'b00,
    IOESEQ_ISSUE = 2'b01,
    IOESEQ_WAIT = 2'b10
  } ioeseq_state_type;
  // one bus step
  typedef struct packed
  {
    logic valid;
    logic rd;
    logic [2:0] cmd;
    logic [7:0] data;
  } ioeseq_step_type;
endpackage : ioeseq_pkg

// ==== ioeseq_steps.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ioeseq_consts.svh"
// step table: picks command and data for expander kind and step index
module ioeseq_steps
  import ioeseq_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [2:0] exp_num,
  input wire logic [3:0] step,
  input wire logic [7:0] out_lo,
  input wire logic [7:0] out_hi,
  input wire logic [7:0] dir_lo,
  input wire logic [7:0] dir_hi,
  output ioeseq_step_type step_q
);
  ioeseq_step_type step_d;
  // pack one step
  function automatic ioeseq_step_type mk(input logic rd, input logic [2:0] c,
                                         input logic [7:0] d);
    ioeseq_step_type s;
    s.valid = 1'b1;
    s.rd = rd;
    s.cmd = c;
    s.data = d;
    return s;
  endfunction : mk
  //////////////////////////////////////////////////////////////////////////////
  // step decode by variant
  always_comb
  begin
    step_d = '0;
    if (exp_num == `IOESEQ_EXP_LED)
    begin
      case (step)
        4'h0: step_d = mk(1'b0, `IOESEQ_REG_OUT_LO, out_lo); // link up
        4'h1: step_d = mk(1'b0, `IOESEQ_REG_OUT_HI, out_hi); // activity
        4'h2: step_d = mk(1'b0, `IOESEQ_REG_POL_LO, `IOESEQ_NO_INVERT);
        4'h3: step_d = mk(1'b0, `IOESEQ_REG_POL_HI, `IOESEQ_NO_INVERT);
        4'h4: step_d = mk(1'b0, `IOESEQ_REG_DIR_LO, `IOESEQ_ALL_OUTPUTS);
        4'h5: step_d = mk(1'b0, `IOESEQ_REG_DIR_HI, `IOESEQ_ALL_OUTPUTS);
        default: step_d = '0; // no input reads
      endcase
    end
    else if (exp_num == `IOESEQ_EXP_PG)
    begin
      case (step)
        4'h0: step_d = mk(1'b0, `IOESEQ_REG_OUT_LO, out_lo); // no upper output write
        4'h1: step_d = mk(1'b0, `IOESEQ_REG_POL_LO, `IOESEQ_NO_INVERT);
        4'h2: step_d = mk(1'b0, `IOESEQ_REG_POL_HI, `IOESEQ_NO_INVERT);
        4'h3: step_d = mk(1'b0, `IOESEQ_REG_DIR_LO, dir_lo);
        4'h4: step_d = mk(1'b0, `IOESEQ_REG_DIR_HI, `IOESEQ_ALL_INPUTS);
        4'h5: step_d = mk(1'b1, `IOESEQ_REG_IN_LO, 8'h00);
        4'h6: step_d = mk(1'b1, `IOESEQ_REG_IN_HI, 8'h00);
        default: step_d = '0;
      endcase
    end
    else
    begin
      case (step)
        4'h0: step_d = mk(1'b0, `IOESEQ_REG_OUT_LO, out_lo);
        4'h1: step_d = mk(1'b0, `IOESEQ_REG_OUT_HI, out_hi);
        4'h2: step_d = mk(1'b0, `IOESEQ_REG_POL_LO, `IOESEQ_NO_INVERT);
        4'h3: step_d = mk(1'b0, `IOESEQ_REG_POL_HI, `IOESEQ_NO_INVERT);
        4'h4: step_d = mk(1'b0, `IOESEQ_REG_DIR_LO, dir_lo);
        4'h5: step_d = mk(1'b0, `IOESEQ_REG_DIR_HI, dir_hi);
        4'h6: step_d = mk(1'b1, `IOESEQ_REG_IN_LO, 8'h00);
        4'h7: step_d = mk(1'b1, `IOESEQ_REG_IN_HI, 8'h00);
        default: step_d = '0;
      endcase
    end
  end
  // registered so the table never sits on a long path
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      step_q <= '0;
    else
      step_q <= step_d;
  end
endmodule : ioeseq_steps
`default_nettype wire

// ==== ioeseq_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ioeseq_consts.svh"
// holds the last read input bytes of expanders 0..2 (small memory, registered read)
module ioeseq_pins
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem_q [0:7]; // index = expander*2 + byte, expanders 0..2 only
  logic [7:0] mem_d [0:7];
  logic [7:0] rd_data_d;
  // next contents
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      mem_d[i] = mem_q[i];
    if (wr_en)
      mem_d[wr_idx] = wr_data;
    rd_data_d = mem_q[rd_idx];
  end
  // register store and read port
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      for (int i = 0; i < 8; i++)
        mem_q[i] <= 8'h00;
      rd_data_q <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
        mem_q[i] <= mem_d[i];
      rd_data_q <= rd_data_d;
    end
  end
endmodule : ioeseq_pins
`default_nettype wire

// ==== ioeseq_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ioeseq_consts.svh"
module ioeseq_top
  import ioeseq_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic EEPROM_DONE,
  input wire logic [5:0] ADDR_WR,
  input wire logic [6:0] ADDR_DATA,
  input wire logic [7:0] HP0_OUT_LO,
  input wire logic [7:0] HP0_OUT_HI,
  input wire logic [7:0] HP1_OUT_LO,
  input wire logic [7:0] HP1_OUT_HI,
  input wire logic [7:0] PG_OUT_LO,
  input wire logic [7:0] HP0_DIR_LO,
  input wire logic [7:0] HP0_DIR_HI,
  input wire logic [7:0] HP1_DIR_LO,
  input wire logic [7:0] HP1_DIR_HI,
  input wire logic [7:0] PG_DIR_LO,
  input wire logic [7:0] LINK_UP,
  input wire logic [7:0] LINK_ACT,
  input wire logic [7:0] PORT_ENABLED,
  input wire logic TXN_DONE,
  input wire logic [7:0] TXN_RDATA,
  output logic TXN_REQ,
  output logic [6:0] TXN_ADDR,
  output logic TXN_RD,
  output logic [2:0] TXN_CMD,
  output logic [7:0] TXN_WDATA,
  output logic [7:0] PIN_STATE,
  output logic PIN_STATE_VALID,
  output logic [2:0] PIN_STATE_IDX,
  output logic BUSY
);
  ////////////////////////////////////////////////////////////////////////////////
  // per-expander address fields and pending flags
  logic [6:0] addr_q [0:5]; // per_expander_bus_address
  logic [6:0] addr_d [0:5];
  logic [5:0] en_q, en_d; // field holds a live address
  logic [5:0] pend_q, pend_d; // configuration requested
  logic [7:0] last_out_q [0:5]; // last lower byte sent per expander
  logic [7:0] last_out_d [0:5];
  logic [7:0] last_hi_q [0:5]; // last upper byte sent
  logic [7:0] last_hi_d [0:5];
  ioeseq_state_type state_q, state_d; // sequencer state
  logic [2:0] cur_q, cur_d; // expander being served
  logic [3:0] step_q, step_d; // step within its sequence
  logic [2:0] rr_q, rr_d; // round-robin start point, keeps service fair
  logic req_q, req_d;
  logic busy_q, busy_d;
  logic [7:0] want_lo [0:5]; // what the pins ought to show now
  logic [7:0] want_hi [0:5];
  logic [7:0] dir_lo_sel, dir_hi_sel;
  logic [5:0] differ; // internal state vs. pins mismatch
  logic [2:0] pick;
  logic pick_ok;
  ioeseq_step_type tab;
  logic cap_en;
  logic [2:0] cap_idx;
  logic [7:0] pin_rd;
  logic [2:0] pidx_q, pidx_d;
  logic pval_q, pval_d;
  logic settle_q, settle_d; // table word still belongs to the previous cur/step
  logic pval2_q, pval2_d; // second stage, waits for the registered memory read
  logic [2:0] pidx2_q, pidx2_d;
  // led bytes: active low, dead ports negated (led off / link down)
  function automatic logic [7:0] led_byte(input logic [7:0] on, input logic [7:0] en);
    return ~(on & en);
  endfunction : led_byte
  ////////////////////////////////////////////////////////////////////////////////
  // desired output bytes, hot-plug passed straight through
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      want_lo[i] = 8'h00;
      want_hi[i] = 8'h00;
    end
    want_lo[0] = HP0_OUT_LO; // not inverted
    want_hi[0] = HP0_OUT_HI;
    want_lo[1] = HP1_OUT_LO;
    want_hi[1] = HP1_OUT_HI;
    want_lo[2] = PG_OUT_LO;
    want_lo[4] = led_byte(LINK_UP, PORT_ENABLED);
    want_hi[4] = led_byte(LINK_ACT, PORT_ENABLED);
  end
  // direction values for the expander in service
  always_comb
  begin
    dir_lo_sel = PG_DIR_LO;
    dir_hi_sel = `IOESEQ_ALL_INPUTS;
    if (cur_q == `IOESEQ_EXP_HP0)
    begin
      dir_lo_sel = HP0_DIR_LO;
      dir_hi_sel = HP0_DIR_HI;
    end
    else if (cur_q == `IOESEQ_EXP_HP1)
    begin
      dir_lo_sel = HP1_DIR_LO;
      dir_hi_sel = HP1_DIR_HI;
    end
  end
  ioeseq_steps u_steps
  (
    .CLK(CLK),
    .RSTN(RSTN),
    .exp_num(cur_q),
    .step(step_q),
    .out_lo(want_lo[cur_q]),
    .out_hi(want_hi[cur_q]),
    .dir_lo(dir_lo_sel),
    .dir_hi(dir_hi_sel),
    .step_q(tab)
  );
  // input bytes captured on reads, for expanders 0..2
  // taken from the issued fields, which hold until the next request
  assign cap_en = (state_q == IOESEQ_WAIT) && TXN_DONE && TXN_RD && (cur_q < 3'h3);
  assign cap_idx = {cur_q[1:0], TXN_CMD[0]};
  ioeseq_pins u_pins
  (
    .CLK(CLK),
    .RSTN(RSTN),
    .wr_en(cap_en),
    .wr_idx(cap_idx),
    .wr_data(TXN_RDATA),
    .rd_idx(pidx_q),
    .rd_data_q(pin_rd)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // mismatch detect and fair pick
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      differ[i] = en_q[i] && ((i == 0) || (i == 1) || (i == 4)) &&
                  ((want_lo[i] != last_out_q[i]) || (want_hi[i] != last_hi_q[i]));
    pick = 3'h0;
    pick_ok = 1'b0;
    for (int k = 5; k >= 0; k--)
    begin
      if ((pend_q[(rr_q + 3'(k)) % 6] || differ[(rr_q + 3'(k)) % 6]) &&
          ((rr_q + 3'(k)) % 6 != 3) && ((rr_q + 3'(k)) % 6 != 5))
      begin
        pick = 3'((rr_q + 3'(k)) % 6);
        pick_ok = 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // next-state for sequencer and fields
  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    step_d = step_q;
    rr_d = rr_q;
    req_d = 1'b0;
    busy_d = (state_q != IOESEQ_IDLE);
    pval_d = 1'b0;
    pidx_d = pidx_q;
    settle_d = 1'b0;
    pval2_d = pval_q; // read port is one cycle behind the write
    pidx2_d = pidx_q;
    en_d = en_q;
    pend_d = pend_q;
    for (int i = 0; i < 6; i++)
    begin
      addr_d[i] = addr_q[i];
      last_out_d[i] = last_out_q[i];
      last_hi_d[i] = last_hi_q[i];
      if (ADDR_WR[i])
      begin
        addr_d[i] = ADDR_DATA; // writing the field requests setup
        en_d[i] = 1'b1;
        pend_d[i] = 1'b1;
      end
    end
    case (state_q)
      IOESEQ_IDLE:
      begin
        if (EEPROM_DONE && pick_ok) // hold off until EEPROM load ends
        begin
          cur_d = pick;
          step_d = 4'h0; // every trigger runs the full sequence
          settle_d = 1'b1;
          pend_d[pick] = ADDR_WR[pick]; // a new write during service re-arms
          rr_d = (pick == 3'h5) ? 3'h0 : 3'(pick + 3'h1);
          state_d = IOESEQ_ISSUE;
        end
      end
      IOESEQ_ISSUE:
      begin
        // table output lags cur/step by one cycle, so wait that cycle out
        if (settle_q)
          state_d = IOESEQ_ISSUE; // stale table word, never issue it
        else if (tab.valid)
        begin
          req_d = 1'b1;
          state_d = IOESEQ_WAIT;
        end
        else if (step_q == `IOESEQ_STEPS)
          state_d = IOESEQ_IDLE;
        else
        begin
          step_d = 4'(step_q + 4'h1); // empty slot of this variant, skip it
          settle_d = 1'b1;
        end
      end
      IOESEQ_WAIT:
      begin
        if (TXN_DONE) // next step only after this one ends
        begin
          // record what was really sent; the wanted byte may have moved since
          if (!TXN_RD && TXN_CMD == `IOESEQ_REG_OUT_LO)
            last_out_d[cur_q] = TXN_WDATA;
          if (!TXN_RD && TXN_CMD == `IOESEQ_REG_OUT_HI)
            last_hi_d[cur_q] = TXN_WDATA;
          if (TXN_RD)
          begin
            pval_d = (cur_q < 3'h3);
            pidx_d = cap_idx;
          end
          step_d = 4'(step_q + 4'h1);
          settle_d = 1'b1;
          state_d = (step_q == 4'(`IOESEQ_STEPS - 4'h1)) ? IOESEQ_IDLE : IOESEQ_ISSUE;
        end
      end
      default:
        state_d = IOESEQ_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  // register all sequencer state
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      state_q <= IOESEQ_IDLE;
      cur_q <= 3'h0;
      step_q <= 4'h0;
      rr_q <= 3'h0;
      req_q <= 1'b0;
      busy_q <= 1'b0;
      pval_q <= 1'b0;
      pidx_q <= 3'h0;
      settle_q <= 1'b0;
      pval2_q <= 1'b0;
      pidx2_q <= 3'h0;
      en_q <= 6'h00;
      pend_q <= 6'h00;
      for (int i = 0; i < 6; i++)
      begin
        addr_q[i] <= 7'h00;
        last_out_q[i] <= 8'h00;
        last_hi_q[i] <= 8'h00;
      end
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      step_q <= step_d;
      rr_q <= rr_d;
      req_q <= req_d;
      busy_q <= busy_d;
      pval_q <= pval_d;
      pidx_q <= pidx_d;
      settle_q <= settle_d;
      pval2_q <= pval2_d;
      pidx2_q <= pidx2_d;
      en_q <= en_d;
      pend_q <= pend_d;
      for (int i = 0; i < 6; i++)
      begin
        addr_q[i] <= addr_d[i];
        last_out_q[i] <= last_out_d[i];
        last_hi_q[i] <= last_hi_d[i];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // transaction port, all from flops
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      TXN_REQ <= 1'b0;
      TXN_ADDR <= 7'h00;
      TXN_RD <= 1'b0;
      TXN_CMD <= 3'h0;
      TXN_WDATA <= 8'h00;
      PIN_STATE_VALID <= 1'b0;
      PIN_STATE_IDX <= 3'h0;
      PIN_STATE <= 8'h00;
      BUSY <= 1'b0;
    end
    else
    begin
      TXN_REQ <= req_d; // single pulse per step
      if (req_d)
      begin
        TXN_ADDR <= addr_q[cur_q];
        TXN_RD <= tab.rd;
        TXN_CMD <= tab.cmd;
        TXN_WDATA <= tab.data;
      end
      PIN_STATE_VALID <= pval2_q; // lines up with the registered read byte
      PIN_STATE_IDX <= pidx2_q;
      PIN_STATE <= pin_rd;
      BUSY <= busy_q;
    end
  end
endmodule : ioeseq_top
`default_nettype wire

// ==== ioeseq_props.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// bus-side watcher, sees only the top ports
module ioeseq_props
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic EEPROM_DONE,
  input wire logic TXN_DONE,
  input wire logic TXN_REQ,
  input wire logic [6:0] TXN_ADDR,
  input wire logic TXN_RD,
  input wire logic [2:0] TXN_CMD,
  input wire logic [7:0] TXN_WDATA,
  input wire logic PIN_STATE_VALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic open_q; // a transaction is in flight
  logic open_d;
  logic [3:0] last_q; // read flag and command of the previous request
  logic [3:0] last_d;
  // next values of the helper state
  always_comb
  begin
    open_d = TXN_REQ ? 1'b1 : (TXN_DONE ? 1'b0 : open_q);
    last_d = TXN_REQ ? {TXN_RD, TXN_CMD} : last_q;
  end
  // helper registers only
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      open_q <= 1'b0;
      last_q <= 4'h0;
    end
    else
    begin
      open_q <= open_d;
      last_q <= last_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence req_wr(c);
    TXN_REQ && !TXN_RD && TXN_CMD == c;
  endsequence
  sequence rd_done;
    TXN_DONE && TXN_RD;
  endsequence
  chk_req_single: assert property (TXN_REQ |=> !TXN_REQ)
    else $error("request longer than one cycle");
  chk_eeprom_gate: assert property (!EEPROM_DONE |-> !TXN_REQ)
    else $error("request before eeprom load done");
  chk_one_outstanding: assert property (TXN_REQ |-> !open_q)
    else $error("request while one in flight");
  chk_done_gap: assert property (TXN_DONE |=> !TXN_REQ [*2])
    else $error("request too soon after done");
  chk_fields_hold: assert property (!TXN_REQ |-> $stable({TXN_ADDR, TXN_RD, TXN_CMD, TXN_WDATA}))
    else $error("command fields moved between requests");
  chk_pol_zero: assert property (req_wr(3'h4) or req_wr(3'h5) |-> TXN_WDATA == 8'h00)
    else $error("polarity write not zero");
  chk_pol_order: assert property (req_wr(3'h5) |-> last_q == 4'h4)
    else $error("upper polarity not after lower");
  chk_dir_order: assert property (req_wr(3'h7) |-> last_q == 4'h6)
    else $error("upper direction not after lower");
  chk_read_order: assert property (TXN_REQ && TXN_RD |->
    (TXN_CMD == 3'h0 && last_q == 4'h7) || (TXN_CMD == 3'h1 && last_q == 4'h8))
    else $error("reads out of order");
  chk_pin_timing: assert property (rd_done |-> ##3 PIN_STATE_VALID)
    else $error("read byte not captured");
endmodule : ioeseq_props
bind ioeseq_top ioeseq_props u_props (.CLK(CLK), .RSTN(RSTN), .EEPROM_DONE(EEPROM_DONE),
  .TXN_DONE(TXN_DONE), .TXN_REQ(TXN_REQ), .TXN_ADDR(TXN_ADDR), .TXN_RD(TXN_RD),
  .TXN_CMD(TXN_CMD), .TXN_WDATA(TXN_WDATA), .PIN_STATE_VALID(PIN_STATE_VALID));
`default_nettype wire

// ==== ioeseq_exp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// bus engine plus expander chips; latency set by the bench
module ioeseq_exp_model
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [3:0] LAT,
  input wire logic TXN_REQ,
  input wire logic [6:0] TXN_ADDR,
  input wire logic TXN_RD,
  input wire logic [2:0] TXN_CMD,
  output logic TXN_DONE,
  output logic [7:0] TXN_RDATA
);
  logic pend; // one transaction in flight
  logic [3:0] cnt; // cycles left
  logic rd; // captured read flag
  logic [7:0] pins; // pin byte, differs per chip and byte
  // read data toggles outside done so stale values never match
  always_ff @(posedge CLK)
  begin
    TXN_DONE <= 1'b0;
    TXN_RDATA <= ~TXN_RDATA;
    if (!RSTN)
    begin
      pend <= 1'b0;
      TXN_RDATA <= 8'h00;
    end
    else if (TXN_REQ)
    begin
      pend <= 1'b1;
      cnt <= LAT;
      rd <= TXN_RD;
      pins <= {1'b1, TXN_ADDR} ^ {7'h00, TXN_CMD[0]};
    end
    else if (pend && cnt == 4'h0)
    begin
      pend <= 1'b0;
      TXN_DONE <= 1'b1;
      TXN_RDATA <= rd ? pins : ~TXN_RDATA;
    end
    else if (pend)
      cnt <= cnt - 4'h1;
  end
endmodule : ioeseq_exp_model
`default_nettype wire

// ==== ioeseq_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ioeseq_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic eeprom_done = 1'b0;
  logic [5:0] addr_wr = 6'h00;
  logic [6:0] addr_data = 7'h00;
  logic [7:0] ob [5] = '{8'h5a, 8'hc3, 8'h96, 8'h3c, 8'he1}; // output bytes
  logic [7:0] db [5] = '{8'h0f, 8'hf0, 8'h33, 8'hcc, 8'h55}; // direction bytes
  logic [7:0] lup = 8'hf3;
  logic [7:0] lact = 8'h3c;
  logic [7:0] pen = 8'h5f; // some ports disabled
  logic [3:0] lat = 4'h1;
  logic req, trd, done, pvalid, busy;
  logic [6:0] taddr;
  logic [2:0] tcmd, pidx;
  logic [7:0] twd, rdata, pst;
  logic [18:0] txq [$]; // requests seen
  logic [10:0] pinq [$]; // captured pin bytes
  logic [11:0] want [$]; // expected read flag, command, data
  int miscompares = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  ioeseq_top u_dut (.CLK(clk), .RSTN(rstn), .EEPROM_DONE(eeprom_done), .ADDR_WR(addr_wr),
    .ADDR_DATA(addr_data), .HP0_OUT_LO(ob[0]), .HP0_OUT_HI(ob[1]), .HP1_OUT_LO(ob[2]),
    .HP1_OUT_HI(ob[3]), .PG_OUT_LO(ob[4]), .HP0_DIR_LO(db[0]), .HP0_DIR_HI(db[1]),
    .HP1_DIR_LO(db[2]), .HP1_DIR_HI(db[3]), .PG_DIR_LO(db[4]), .LINK_UP(lup),
    .LINK_ACT(lact), .PORT_ENABLED(pen), .TXN_DONE(done), .TXN_RDATA(rdata), .TXN_REQ(req),
    .TXN_ADDR(taddr), .TXN_RD(trd), .TXN_CMD(tcmd), .TXN_WDATA(twd), .PIN_STATE(pst),
    .PIN_STATE_VALID(pvalid), .PIN_STATE_IDX(pidx), .BUSY(busy));
  ioeseq_exp_model u_exp (.CLK(clk), .RSTN(rstn), .LAT(lat), .TXN_REQ(req), .TXN_ADDR(taddr),
    .TXN_RD(trd), .TXN_CMD(tcmd), .TXN_DONE(done), .TXN_RDATA(rdata));
  // log every request and every captured byte
  always @(posedge clk)
  begin
    if (req === 1'b1)
      txq.push_back({taddr, trd, tcmd, twd});
    if (pvalid === 1'b1)
      pinq.push_back({pidx, pst});
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic add(input logic rd, input logic [2:0] c, input logic [7:0] d);
    want.push_back({rd, c, d});
  endtask : add
  task automatic start(input int e, input logic [6:0] a);
    addr_data <= a;
    addr_wr <= 6'h01 << e;
    tick(1);
    addr_wr <= 6'h00;
  endtask : start
  // waits for the expected number of requests, then compares in order
  task automatic collect(input int e, input logic [6:0] a);
    int n;
    logic [11:0] w;
    logic [18:0] t;
    n = want.size();
    for (int i = 0; i < 600 && txq.size() < n; i++)
      tick(1);
    if (txq.size() < n)
    begin
      miscompares++;
      print_verdict();
    end
    check(19'(busy), 19'h1);
    tick(30);
    check(19'(txq.size()), 19'(n));
    check(19'(busy), 19'h0);
    while (want.size() > 0)
    begin
      w = want.pop_front();
      t = txq.pop_front();
      check({t[18:8], t[11] ? 8'h00 : t[7:0]}, {a, w[11:8], w[11] ? 8'h00 : w[7:0]});
      if (w[11])
        check({8'h00, pinq.pop_front()}, {8'h00, 3'(e * 2 + w[8]), {1'b1, a} ^ {7'h00, w[8]}});
    end
    check(19'(pinq.size()), 19'h0);
  endtask : collect
  task automatic hp_list(input int k);
    add(1'b0, 3'h2, ob[2 * k]);
    add(1'b0, 3'h3, ob[2 * k + 1]);
    add(1'b0, 3'h4, 8'h00);
    add(1'b0, 3'h5, 8'h00);
    add(1'b0, 3'h6, db[2 * k]);
    add(1'b0, 3'h7, db[2 * k + 1]);
    add(1'b1, 3'h0, 8'h00);
    add(1'b1, 3'h1, 8'h00);
  endtask : hp_list
  ////////////////////////////////////////////////////////////////////////////////
  // address written while the eeprom is still loading: held back
  task automatic t_hotplug0;
    start(0, 7'h20);
    tick(40);
    check(19'(txq.size()), 19'h0);
    eeprom_done <= 1'b1;
    hp_list(0);
    collect(0, 7'h20);
  endtask : t_hotplug0
  // power-good chip with a slow bus
  task automatic t_power_good;
    lat <= 4'h6;
    add(1'b0, 3'h2, ob[4]);
    add(1'b0, 3'h4, 8'h00);
    add(1'b0, 3'h5, 8'h00);
    add(1'b0, 3'h6, db[4]);
    add(1'b0, 3'h7, 8'hff);
    add(1'b1, 3'h0, 8'h00);
    add(1'b1, 3'h1, 8'h00);
    start(2, 7'h22);
    collect(2, 7'h22);
    lat <= 4'h1;
  endtask : t_power_good
  // led chip: active low, disabled ports dark
  task automatic t_led;
    add(1'b0, 3'h2, ~(lup & pen));
    add(1'b0, 3'h3, ~(lact & pen));
    add(1'b0, 3'h4, 8'h00);
    add(1'b0, 3'h5, 8'h00);
    add(1'b0, 3'h6, 8'h00);
    add(1'b0, 3'h7, 8'h00);
    start(4, 7'h24);
    collect(4, 7'h24);
  endtask : t_led
  // internal output state changes after setup: chip brought back in line
  task automatic t_resync;
    hp_list(1);
    start(1, 7'h21);
    collect(1, 7'h21);
    ob[3] <= 8'h81;
    tick(1);
    hp_list(1);
    collect(1, 7'h21);
  endtask : t_resync
  initial
  begin
    tick(5);
    rstn <= 1'b1;
    tick(2);
    t_hotplug0();
    t_power_good();
    t_led();
    t_resync();
    print_verdict();
  end
endmodule : ioeseq_tb_top
`default_nettype wire
